// [tb/capture_model.sv]
// Capture logic model that takes each output word at data ready's fall.
`timescale 1ns/10ps
module capture_model (
  // Port pins
  input wire logic [7:0] primaryPortBits,
  input wire logic [7:0] primaryPortBitsN,
  input wire logic [7:0] auxiliaryPortBits,
  input wire logic [7:0] auxiliaryPortBitsN,
  input wire logic overrange,
  input wire logic overrangeN,
  input wire logic dataReadyClock,
  // Captured word
  output logic [7:0] capPrim,
  output logic [7:0] capAux,
  output logic capOver,
  output logic diffOk,
  output int capCount
);
  // ------------------------------------------------------------
  // Capture
  // ------------------------------------------------------------
  // Start from a known state so the first fall is counted cleanly.
  initial begin
    capPrim = 8'h00;
    capAux = 8'h00;
    capOver = 1'b0;
    diffOk = 1'b1;
    capCount = 0;
  end

  // The word is taken on the fall with no added delay; the complement
  // legs are judged at that same moment. A powered-down auxiliary pair
  // shows both legs high, which a receiver must accept.
  always @(negedge dataReadyClock) begin
    capPrim <= primaryPortBits;
    capAux <= auxiliaryPortBits;
    capOver <= overrange;
    capCount <= capCount + 1;
    if ({primaryPortBitsN, overrangeN} !== ~{primaryPortBits, overrange}
        || (auxiliaryPortBitsN !== ~auxiliaryPortBits
        && {auxiliaryPortBits, auxiliaryPortBitsN} !== 16'hFFFF)) begin
      diffOk <= 1'b0;
    end
  end
endmodule

// [tb/tb_adc_output_demux.sv]
// Self-checking bench for the converter output demultiplexer.
`timescale 1ns/10ps
module tb_adc_output_demux;
  import adc_demux_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  sample_t sampleIn = '0;
  logic sampleValid = 1'b0;
  logic splitEnable = 1'b0;
  logic secondPortEnableA = 1'b0;
  logic secondPortEnableB = 1'b0;
  logic [2:0] rateDividerSelect = 3'h0;
  logic demuxResetIn = 1'b0;
  logic [7:0] primaryPortBits, primaryPortBitsN;
  logic [7:0] auxiliaryPortBits, auxiliaryPortBitsN;
  logic overrange, overrangeN, dataReadyClock, dataReadyClockN;
  logic demuxResetOut, demuxResetOutN;
  logic [7:0] capPrim, capAux;
  logic capOver, diffOk;
  int capCount;
  int failCount = 0;
  int compares = 0;

  adc_output_demux adc_output_demux_inst (.clk(clk), .arst_n(arst_n),
    .sampleIn(sampleIn), .sampleValid(sampleValid),
    .splitEnable(splitEnable), .secondPortEnableA(secondPortEnableA),
    .secondPortEnableB(secondPortEnableB),
    .rateDividerSelect(rateDividerSelect), .demuxResetIn(demuxResetIn),
    .primaryPortBits(primaryPortBits), .primaryPortBitsN(primaryPortBitsN),
    .auxiliaryPortBits(auxiliaryPortBits),
    .auxiliaryPortBitsN(auxiliaryPortBitsN), .overrange(overrange),
    .overrangeN(overrangeN), .dataReadyClock(dataReadyClock),
    .dataReadyClockN(dataReadyClockN), .demuxResetOut(demuxResetOut),
    .demuxResetOutN(demuxResetOutN));

  capture_model capture_model_inst (.primaryPortBits(primaryPortBits),
    .primaryPortBitsN(primaryPortBitsN),
    .auxiliaryPortBits(auxiliaryPortBits),
    .auxiliaryPortBitsN(auxiliaryPortBitsN), .overrange(overrange),
    .overrangeN(overrangeN), .dataReadyClock(dataReadyClock),
    .capPrim(capPrim), .capAux(capAux), .capOver(capOver),
    .diffOk(diffOk), .capCount(capCount));

  // Free-running sample clock.
  always #5 clk = ~clk;

  // ------------------------------------------------------------
  // Compare and drive tasks
  // ------------------------------------------------------------
  task automatic checkByte(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      failCount++;
      $display("mismatch at %0t: byte %h expected %h", $time, got, exp);
    end
  endtask

  task automatic checkBit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      failCount++;
      $display("mismatch at %0t: bit %b expected %b", $time, got, exp);
    end
  endtask

  // Pins pass synchronisers, so the mode settles before any sample.
  task automatic setMode(input logic sp, a, b, input logic [2:0] div);
    splitEnable = sp;
    secondPortEnableA = a;
    secondPortEnableB = b;
    rateDividerSelect = div;
    repeat (6) @(negedge clk);
  endtask

  // Sends n samples two cycles apart, then judges the captured word.
  task automatic sendCheck(input int n, input sample_t s0, s1, s2, s3,
      input logic [7:0] ePrim, eAux, input logic eOver);
    int base;
    int i;
    sample_t s [4];
    base = capCount;
    s = '{s0, s1, s2, s3};
    for (int k = 0; k < n; k++) begin
      sampleIn = s[k];
      sampleValid = 1'b1;
      @(negedge clk);
      sampleValid = 1'b0;
      @(negedge clk);
    end
    i = 0;
    while (capCount <= base && i < 40) begin
      @(negedge clk);
      i++;
    end
    checkBit(capCount > base, 1'b1);
    checkByte(capPrim, ePrim);
    checkByte(capAux, eAux);
    checkBit(capOver, eOver);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic testHalf();
    setMode(1'b1, 1'b1, 1'b1, 3'h2);
    sendCheck(2, {1'b0, 8'h7F}, {1'b1, 8'hFF}, '0, '0,
      8'h7F, 8'hFF, 1'b1);
    sendCheck(2, {1'b1, 8'hFF}, {1'b0, 8'h00}, '0, '0,
      8'hFF, 8'h00, 1'b1);
    sendCheck(2, {1'b0, 8'h80}, {1'b0, 8'h01}, '0, '0,
      8'h80, 8'h01, 1'b0);
    $display("test half rate done");
  endtask

  task automatic testQuarter();
    setMode(1'b1, 1'b1, 1'b1, 3'h4);
    sendCheck(4, {1'b0, 8'h11}, {1'b1, 8'hFF}, {1'b0, 8'h22},
      {1'b0, 8'h33}, 8'h11, 8'h22, 1'b0);
    sendCheck(4, {1'b0, 8'h44}, {1'b0, 8'h55}, {1'b1, 8'hFF},
      {1'b0, 8'h66}, 8'h44, 8'hFF, 1'b1);
    $display("test quarter rate done");
  endtask

  task automatic testFull();
    setMode(1'b0, 1'b0, 1'b0, 3'h4);
    sendCheck(1, {1'b1, 8'hFF}, '0, '0, '0, 8'hFF, 8'hFF, 1'b1);
    sendCheck(1, {1'b0, 8'h00}, '0, '0, '0, 8'h00, 8'hFF, 1'b0);
    sendCheck(1, {1'b0, 8'h5A}, '0, '0, '0, 8'h5A, 8'hFF, 1'b0);
    $display("test full rate done");
  endtask

  task automatic testAuxOff();
    setMode(1'b1, 1'b1, 1'b0, 3'h2);
    sendCheck(2, {1'b0, 8'h12}, {1'b1, 8'hFF}, '0, '0,
      8'h12, 8'hFF, 1'b0);
    setMode(1'b1, 1'b0, 1'b1, 3'h2);
    sendCheck(2, {1'b0, 8'h34}, {1'b1, 8'hF0}, '0, '0,
      8'h34, 8'hFF, 1'b0);
    $display("test auxiliary off done");
  endtask

  task automatic testReset();
    int i;
    int base;
    setMode(1'b1, 1'b1, 1'b1, 3'h2);
    // A lone sample waits in hold for its partner; no word may leave.
    base = capCount;
    sampleIn = {1'b0, 8'hAA};
    sampleValid = 1'b1;
    @(negedge clk);
    sampleValid = 1'b0;
    repeat (8) @(negedge clk);
    checkBit(capCount == base, 1'b1);
    checkBit(dataReadyClock, 1'b0);
    checkByte(primaryPortBits, 8'h34);
    checkByte(primaryPortBitsN, 8'hCB);
    demuxResetIn = 1'b1;
    i = 0;
    while (demuxResetOut !== 1'b1 && i < 8) begin
      @(negedge clk);
      i++;
    end
    checkBit(demuxResetOut, 1'b1);
    checkBit(demuxResetOutN, 1'b0);
    demuxResetIn = 1'b0;
    repeat (6) @(negedge clk);
    checkBit(demuxResetOut, 1'b0);
    sendCheck(2, {1'b0, 8'hBB}, {1'b0, 8'hCC}, '0, '0,
      8'hBB, 8'hCC, 1'b0);
    $display("test demux reset done");
  endtask

  // ------------------------------------------------------------
  // Verdict
  // ------------------------------------------------------------
  task automatic results();
    $display("compares %0d mismatches %0d", compares, failCount);
    if (failCount == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Main sequence; the reset test must drop the sample left in hold.
  initial begin
    repeat (2) @(negedge clk);
    arst_n = 1'b1;
    repeat (2) @(negedge clk);
    checkByte(auxiliaryPortBits, 8'hFF);
    testHalf();
    testQuarter();
    testFull();
    testAuxOff();
    testReset();
    checkBit(diffOk, 1'b1);
    results();
  end

  // The whole run takes about a microsecond; far beyond that is a hang.
  initial begin
    #50us;
    failCount++;
    $display("mismatch at %0t: watchdog expired", $time);
    results();
  end
endmodule

// [verilog/adc_demux_defs.svh]
// Constants for the converter output demultiplexer.
`ifndef ADC_DEMUX_DEFS_SVH
`define ADC_DEMUX_DEFS_SVH

// ----------------------------------------------------------------
// Control encodings
// ----------------------------------------------------------------
`define DIVSEL_HALF 3'h2
`define DIVSEL_QUARTER 3'h4

// ----------------------------------------------------------------
// Reset values and timing counts
// ----------------------------------------------------------------
`define BYTE_RESET 8'h00
`define BYTE_ALL_ONES 8'hFF
`define CTRL_PINS_RESET 6'h15
`define SAMPLE_DIV_DEFAULT 4'h2
`define SYNC_WIDTH 7
`define CYC_MAX 4'hF

`endif

// [verilog/adc_demux_pkg.sv]
// Types shared by the converter output demultiplexer files.
package adc_demux_pkg;

  // One converted sample with its overrange mark.
  typedef struct packed {
    logic over;
    logic [7:0] bits;
  } sample_t;

  // Rate modes of the output stage.
  typedef enum logic [1:0] {
    full_rate_mode,
    half_rate_split_mode,
    quarter_rate_decimate_mode
  } mode_t;

endpackage

// [verilog/adc_output_demux.sv]
// Output stage of an 8-bit converter: rate modes, ports and data ready.
`timescale 1ns/10ps
`include "adc_demux_defs.svh"

// Function
// - Half rate puts two consecutive samples on primary and auxiliary ports.
// - Full rate bypasses the demultiplexer; every sample on primary only.
// - Two separate enables power down the auxiliary port.
// - Quarter rate drops every second sample, output at quarter rate.
// - Split modes flag overrange if either port holds an overranged sample; with the auxiliary port off, only from primary.
// - Full rate flags overrange only from the primary port.
// - Ports and overrange update on the rising edge of data ready.
// - Data ready falls near the centre of each valid data window.
// - Eight bits per port, bit 0 LSB, true and complementary outputs.
// - Reset input realigns the demultiplexer and is passed on outward.
// - Samples pass in offset binary with their overrange mark unchanged.
module adc_output_demux
  import adc_demux_pkg::*;
#(
  parameter logic [3:0] SAMPLE_DIV = `SAMPLE_DIV_DEFAULT
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Converter core samples, same clock
  input wire sample_t sampleIn,
  input wire logic sampleValid,
  // Control pins
  input wire logic splitEnable,
  input wire logic secondPortEnableA,
  input wire logic secondPortEnableB,
  input wire logic [2:0] rateDividerSelect,
  input wire logic demuxResetIn,
  // Primary and auxiliary ports
  output logic [7:0] primaryPortBits,
  output logic [7:0] primaryPortBitsN,
  output logic [7:0] auxiliaryPortBits,
  output logic [7:0] auxiliaryPortBitsN,
  // Overrange and data ready
  output logic overrange,
  output logic overrangeN,
  output logic dataReadyClock,
  output logic dataReadyClockN,
  // Reset passed on
  output logic demuxResetOut,
  output logic demuxResetOutN
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------

  // Mode from the synchronised pins; odd divider values act as half.
  function automatic mode_t decodeMode(input logic split,
                                       input logic [2:0] div);
    decodeMode = half_rate_split_mode;
    if (!split) begin
      decodeMode = full_rate_mode;
    end else if (div == `DIVSEL_QUARTER) begin
      decodeMode = quarter_rate_decimate_mode;
    end
  endfunction

  // Clock cycles from a data ready rise to its fall: half a word period.
  function automatic logic [3:0] halfCycles(input mode_t m);
    logic [7:0] full;
    case (m)
      full_rate_mode: full = {4'h0, SAMPLE_DIV};
      half_rate_split_mode: full = {3'h0, SAMPLE_DIV, 1'b0};
      default: full = {2'h0, SAMPLE_DIV, 2'h0};
    endcase
    if (full < 8'h04) begin
      halfCycles = 4'h1;
    end else begin
      halfCycles = full[4:1];
    end
  endfunction

  // ----------------------------------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------------------------------
  logic rstMeta_ff, rstN;
  logic [`SYNC_WIDTH-1:0] syncedPins;
  logic auxOn, demuxRst;
  mode_t pinMode;

  // Reset enters asynchronously and leaves through two flops.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rstMeta_ff <= 1'b0;
      rstN <= 1'b0;
    end else begin
      rstMeta_ff <= 1'b1;
      rstN <= rstMeta_ff;
    end
  end

  pin_sync #(.WIDTH(`SYNC_WIDTH)) u_pin_sync (
    .clk(clk),
    .rstN(rstN),
    .pinIn({demuxResetIn, rateDividerSelect, secondPortEnableB,
            secondPortEnableA, splitEnable}),
    .syncOut(syncedPins)
  );

  // Either enable off powers the auxiliary port down.
  assign auxOn = syncedPins[1] & syncedPins[2];
  assign demuxRst = syncedPins[6];
  assign pinMode = decodeMode(syncedPins[0], syncedPins[5:3]);

  // ----------------------------------------------------------------
  // Demultiplexer and output state
  // ----------------------------------------------------------------
  mode_t mode_ff, nxt_mode;
  logic [1:0] phase_ff, nxt_phase;
  sample_t hold_ff, nxt_hold;
  sample_t pri_ff, nxt_pri;
  sample_t aux_ff, nxt_aux;
  logic auxOn_ff, nxt_auxOn;
  logic drdy_ff, nxt_drdy;
  logic [3:0] cyc_ff, nxt_cyc;
  logic nxt_demux_reset_out;
  logic update;

  // Samples collect in hold; a word leaves with a data ready rise.
  // A mode change or reset realigns the phase so pairs never straddle.
  always_comb begin
    nxt_mode = pinMode;
    nxt_phase = phase_ff;
    nxt_hold = hold_ff;
    nxt_pri = pri_ff;
    nxt_aux = aux_ff;
    nxt_auxOn = auxOn;
    nxt_drdy = drdy_ff;
    nxt_cyc = (cyc_ff == `CYC_MAX) ? cyc_ff : cyc_ff + 4'h1;
    nxt_demux_reset_out = demuxRst;
    update = 1'b0;
    if (demuxRst || pinMode != mode_ff) begin
      nxt_phase = 2'h0;
      nxt_drdy = 1'b0;
    end else begin
      if (sampleValid) begin
        case (mode_ff)
          full_rate_mode: begin
            nxt_pri = sampleIn;
            update = 1'b1;
          end
          half_rate_split_mode: begin
            if (phase_ff == 2'h0) begin
              nxt_hold = sampleIn;
              nxt_phase = 2'h1;
            end else begin
              nxt_pri = hold_ff;
              nxt_aux = sampleIn;
              nxt_phase = 2'h0;
              update = 1'b1;
            end
          end
          default: begin
            // Odd phases are the discarded samples.
            nxt_phase = phase_ff + 2'h1;
            if (phase_ff == 2'h0) begin
              nxt_hold = sampleIn;
            end else if (phase_ff == 2'h2) begin
              nxt_pri = hold_ff;
              nxt_aux = sampleIn;
              update = 1'b1;
            end
          end
        endcase
      end
      if (update) begin
        nxt_drdy = 1'b1;
        nxt_cyc = 4'h0;
      end else if (drdy_ff && cyc_ff + 4'h1 == halfCycles(mode_ff)) begin
        nxt_drdy = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      mode_ff <= full_rate_mode;
      phase_ff <= 2'h0;
      hold_ff <= '0;
      pri_ff <= '0;
      aux_ff <= '0;
      auxOn_ff <= 1'b0;
      drdy_ff <= 1'b0;
      cyc_ff <= 4'h0;
    end else begin
      mode_ff <= nxt_mode;
      phase_ff <= nxt_phase;
      hold_ff <= nxt_hold;
      pri_ff <= nxt_pri;
      aux_ff <= nxt_aux;
      auxOn_ff <= nxt_auxOn;
      drdy_ff <= nxt_drdy;
      cyc_ff <= nxt_cyc;
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  logic [37:0] pins_ff, nxt_pins;
  logic [15:0] nxt_auxPair;
  logic nxt_or;

  // Every leg of every pin in port order; pins take the next-state word, so they
  // change with the word registers and data ready stays aligned. A powered-down auxiliary pair
  // floats high on both legs, as the open-emitter drivers do.
  always_comb begin
    nxt_or = nxt_pri.over | nxt_aux.over;
    nxt_auxPair = {nxt_aux.bits, ~nxt_aux.bits};
    if (nxt_mode == full_rate_mode || !nxt_auxOn) begin
      nxt_or = nxt_pri.over;
      nxt_auxPair = {`BYTE_ALL_ONES, `BYTE_ALL_ONES};
    end
    nxt_pins = {nxt_pri.bits, ~nxt_pri.bits, nxt_auxPair, nxt_or, ~nxt_or,
      nxt_drdy, ~nxt_drdy, nxt_demux_reset_out, ~nxt_demux_reset_out};
  end

  // One register for all legs keeps pins and data ready in step.
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      pins_ff <= {`BYTE_RESET, `BYTE_ALL_ONES, `BYTE_ALL_ONES,
        `BYTE_ALL_ONES, `CTRL_PINS_RESET};
    end else begin
      pins_ff <= nxt_pins;
    end
  end

  assign {primaryPortBits, primaryPortBitsN, auxiliaryPortBits,
    auxiliaryPortBitsN, overrange, overrangeN, dataReadyClock,
    dataReadyClockN, demuxResetOut, demuxResetOutN} = pins_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstN);

  sequence s_first_half;
    sampleValid && mode_ff == half_rate_split_mode && phase_ff == 2'h0
      && !demuxRst && pinMode == mode_ff;
  endsequence
  sequence s_second_half;
    sampleValid && mode_ff == half_rate_split_mode && !demuxRst
      && pinMode == mode_ff;
  endsequence

  a_half_pair_order: assert property (
    s_first_half ##1 (!sampleValid && !demuxRst && pinMode == mode_ff)
      ##1 s_second_half
    |=> primaryPortBits == $past(hold_ff.bits) && pri_ff == $past(hold_ff))
    else $error("half rate pair out of order");
  a_full_primary: assert property (
    sampleValid && mode_ff == full_rate_mode && !demuxRst
      && pinMode == mode_ff
    |=> primaryPortBits == $past(sampleIn.bits) && dataReadyClock)
    else $error("full rate sample missed primary port");
  a_aux_off_static: assert property (
    (!auxOn || mode_ff == full_rate_mode)[*2]
    |-> auxiliaryPortBits == 8'hFF && auxiliaryPortBitsN == 8'hFF)
    else $error("disabled auxiliary port not static");
  a_quarter_keep: assert property (
    $rose(drdy_ff) && mode_ff == quarter_rate_decimate_mode
    |-> $past(phase_ff) == 2'h2 && phase_ff == 2'h3)
    else $error("quarter rate word from wrong phase");
  a_or_split: assert property (
    mode_ff != full_rate_mode && auxOn_ff
    |-> overrange == (pri_ff.over | aux_ff.over))
    else $error("split overrange not primary or auxiliary");
  a_or_full: assert property (
    mode_ff == full_rate_mode |-> overrange == pri_ff.over)
    else $error("full rate overrange not from primary");
  a_data_on_rise: assert property (
    $changed(pri_ff) |-> $rose(drdy_ff))
    else $error("port changed without data ready rise");
  a_drdy_centre: assert property (
    $fell(drdy_ff) && !$past(demuxRst) && $past(pinMode) == $past(mode_ff)
    |-> $past(cyc_ff) + 4'h1 == halfCycles($past(mode_ff)))
    else $error("data ready fell off centre");
  a_true_comp: assert property (
    primaryPortBitsN == ~primaryPortBits && overrangeN == ~overrange
      && dataReadyClockN == ~dataReadyClock)
    else $error("complementary output mismatch");
  a_reset_out: assert property (
    demuxRst |=> phase_ff == 2'h0 && !drdy_ff && demuxResetOut)
    else $error("demux reset not applied or passed on");

endmodule

// [verilog/pin_sync.sv]
// Two-stage synchroniser for a group of pin levels.
`timescale 1ns/10ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstN,
  // Levels
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_ff;
  logic [WIDTH-1:0] syncOut_ff;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      stage1_ff <= '0;
      syncOut_ff <= '0;
    end else begin
      stage1_ff <= pinIn;
      syncOut_ff <= stage1_ff;
    end
  end

  assign syncOut = syncOut_ff;

endmodule
